// [bench/rac_core_test.sv]
// rac_core_test: self-checking bench for the alarm, calibration and
// timestamp block; drives the register port, calendar and pins itself.
// assumes rac_pkg and rac_core are compiled ahead of this file.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
  n_mismatch++; \
  $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module rac_core_test
  import rac_pkg::*;
;
  localparam int          CYCLE_LIMIT = 10000;
  localparam logic [63:0] ALARM_SET   = 64'h2500_1234_1503_2412;

  logic        clock;
  logic        rst_b;
  logic        por_b;
  logic [3:0]  addr;
  logic [15:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [15:0] rd_data;
  logic [15:0] cur_time_low;
  logic [15:0] cur_time_high;
  logic [15:0] cur_date_low;
  logic [15:0] cur_date_high;
  logic        osc_in;
  logic        tamper_input;
  logic        half_tick;
  logic        alarm_irq;
  logic        capture_irq;
  logic        clock_pin_output_enable;
  logic [2:0]  osc_cnt;
  int          n_mismatch;
  int          checks_done;
  int          n_alarm;
  int          n_tick;
  int          n_capture;
  int          n_cycle;

  rac_core rac_core_inst (
    .clock                   (clock),
    .rst_b                   (rst_b),
    .por_b                   (por_b),
    .addr                    (addr),
    .wr_data                 (wr_data),
    .wr_en                   (wr_en),
    .rd_en                   (rd_en),
    .rd_data                 (rd_data),
    .cur_time_low            (cur_time_low),
    .cur_time_high           (cur_time_high),
    .cur_date_low            (cur_date_low),
    .cur_date_high           (cur_date_high),
    .osc_in                  (osc_in),
    .tamper_input            (tamper_input),
    .half_tick               (half_tick),
    .alarm_irq               (alarm_irq),
    .capture_irq             (capture_irq),
    .clock_pin_output_enable (clock_pin_output_enable)
  );

  // ------------------------------------------------------------------
  // clock, oscillator pin (8 clocks a period) and event counters
  // ------------------------------------------------------------------
  always #2 clock = ~clock;

  always @(posedge clock) begin
    osc_cnt <= osc_cnt + 3'h1;
    osc_in  <= osc_cnt[2];
  end

  always @(posedge clock) begin
    n_cycle++;
    if (alarm_irq === 1'b1) n_alarm++;
    if (half_tick === 1'b1) n_tick++;
    if (capture_irq === 1'b1) n_capture++;
    if (n_cycle == CYCLE_LIMIT) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask : reg_write

  task automatic reg_check(input logic [3:0] a, input logic [15:0] e,
                           input string nm);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    `CHK(nm, e, rd_data)
  endtask : reg_check

  task automatic soft_reset();
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
  endtask : soft_reset

  task automatic set_cur(input logic [63:0] v);
    @(posedge clock);
    {cur_time_low, cur_time_high, cur_date_low, cur_date_high} <= v;
  endtask : set_cur

  task automatic tamper_pulse();
    @(posedge clock);
    tamper_input <= 1'b0;
    repeat (4) @(posedge clock);
    tamper_input <= 1'b1;
    repeat (12) @(negedge clock);
  endtask : tamper_pulse

  task automatic alarm_wait(input int cyc, input int n, input logic [15:0] c);
    int b;
    b = n_alarm;
    repeat (cyc) @(negedge clock);
    `CHK("alarm count", n, n_alarm - b)
    reg_check(OFF_CONTROL_ONE_HIGH, c, "control high");
  endtask : alarm_wait

  task automatic wait_alarm(output int t);
    int b;
    b = n_alarm;
    for (int i = 0; i < 100 && n_alarm == b; i++) @(negedge clock);
    t = n_cycle;
  endtask : wait_alarm

  // one digit of the calendar flipped for each interval code 2 to 9
  function automatic logic [63:0] flip(input int k);
    case (k)
      2:       flip = 64'h0100_0000_0000_0000;
      3:       flip = 64'h1000_0000_0000_0000;
      4:       flip = 64'h0000_0001_0000_0000;
      5:       flip = 64'h0000_0010_0000_0000;
      6:       flip = 64'h0000_0100_0000_0000;
      7:       flip = 64'h0000_0000_0001_0000;
      8:       flip = 64'h0000_0000_0100_0000;
      9:       flip = 64'h0000_0000_0000_0001;
      default: flip = 64'h0000_0000_0000_1000;
    endcase
  endfunction : flip

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_regs();
    reg_check(OFF_COARSE_PRESCALE, 16'h4000, "coarse");
    reg_check(OFF_FINE_PRESCALE, 16'h0000, "fine");
    reg_check(OFF_CONTROL_ONE_HIGH, 16'h0000, "control high");
    reg_check(OFF_STATUS, 16'h0000, "status");
    reg_check(OFF_TS_TIME_HIGH, 16'h0000, "ts time");
    reg_check(OFF_TS_DATE_LOW, 16'h0000, "ts date low");
    reg_check(OFF_TS_DATE_HIGH, 16'h0000, "ts date high");
    reg_write(4'hc, 16'hffff);
    reg_check(4'hc, 16'h0000, "unmapped");
    reg_write(OFF_CONTROL_ONE_LOW, 16'h0080);
    repeat (2) @(negedge clock);
    `CHK("pin oe", 1'b1, clock_pin_output_enable)
  endtask : test_reset_regs

  task automatic test_storage();
    reg_write(OFF_TS_TIME_HIGH, 16'hffff);
    reg_write(OFF_TS_DATE_LOW, 16'hffff);
    reg_write(OFF_TS_DATE_HIGH, 16'hffff);
    soft_reset();
    reg_check(OFF_TS_TIME_HIGH, 16'hffff, "ts time");
    reg_check(OFF_TS_DATE_LOW, 16'hffff, "ts date low");
    reg_check(OFF_TS_DATE_HIGH, 16'hffff, "ts date high");
    reg_check(OFF_CONTROL_ONE_LOW, 16'h0000, "control low");
    reg_write(OFF_CONTROL_ONE_LOW, 16'h0001);
    reg_check(OFF_TS_TIME_HIGH, 16'h3f7f, "ts time");
    reg_check(OFF_TS_DATE_LOW, 16'h3f07, "ts date low");
    reg_check(OFF_TS_DATE_HIGH, 16'hff1f, "ts date high");
  endtask : test_storage

  task automatic test_capture();
    int b;
    set_cur(64'h0000_d3d9_e1fe_24f2);
    reg_write(OFF_CONTROL_ONE_LOW, 16'h0001);
    b = n_capture;
    tamper_pulse();
    `CHK("captures", 1, n_capture - b)
    reg_check(OFF_TS_TIME_HIGH, 16'h1359, "ts time");
    reg_check(OFF_TS_DATE_LOW, 16'h2106, "ts date low");
    reg_check(OFF_TS_DATE_HIGH, 16'h2412, "ts date high");
    reg_check(OFF_STATUS, 16'h0008, "status");
    set_cur(64'h0000_0815_0000_0000);
    tamper_pulse();
    `CHK("captures", 1, n_capture - b)
    reg_check(OFF_TS_TIME_HIGH, 16'h1359, "ts time");
    reg_write(OFF_STATUS, 16'h0000);
    reg_check(OFF_STATUS, 16'h0000, "status");
    reg_write(OFF_STATUS, 16'h0008);
    repeat (4) @(negedge clock);
    `CHK("captures", 2, n_capture - b)
    reg_check(OFF_TS_TIME_HIGH, 16'h0815, "ts time");
    reg_write(OFF_CONTROL_ONE_LOW, 16'h0000);
    reg_write(OFF_STATUS, 16'h0000);
    tamper_pulse();
    `CHK("captures", 2, n_capture - b)
  endtask : test_capture

  task automatic ticks_for(input logic [15:0] c, input logic [15:0] f,
                           output int n);
    int b;
    reg_write(OFF_COARSE_PRESCALE, c);
    reg_write(OFF_FINE_PRESCALE, f);
    repeat (32) @(negedge clock);
    b = n_tick;
    repeat (192) @(negedge clock);
    n = n_tick - b;
  endtask : ticks_for

  // 192 clocks hold 24 oscillator edges; each edge adds 32
  task automatic test_prescale();
    int n1;
    int n2;
    int n3;
    soft_reset();
    ticks_for(16'h0001, 16'h0000, n1);
    ticks_for(16'h0001, 16'h0010, n2);
    ticks_for(16'h0002, 16'h0000, n3);
    `CHK("ticks 32", 24, n1)
    `CHK("ticks 48", 16, n2)
    `CHK("ticks 64", 12, n3)
    reg_write(OFF_COARSE_PRESCALE, 16'h0001);
  endtask : test_prescale

  task automatic test_alarm_counts();
    int b;
    int t1;
    int t2;
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h8000);
    alarm_wait(80, 1, 16'h0000);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h8002);
    alarm_wait(80, 3, 16'h0000);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h80ff);
    alarm_wait(2200, 256, 16'h0000);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'hc001);
    b = n_alarm;
    for (int i = 0; i < 100 && n_alarm - b < 3; i++) @(negedge clock);
    reg_check(OFF_CONTROL_ONE_HIGH, 16'hc0fe, "endless");
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h4000);
    alarm_wait(48, 0, 16'h4000);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h8101);
    wait_alarm(t1);
    wait_alarm(t2);
    `CHK("second gap", 16, t2 - t1)
    reg_check(OFF_CONTROL_ONE_HIGH, 16'h0100, "control high");
  endtask : test_alarm_counts

  task automatic test_digits();
    reg_write(OFF_ALARM_TIME_LOW, 16'h2500);
    reg_write(OFF_ALARM_TIME_HIGH, 16'h1234);
    reg_write(OFF_ALARM_DATE_LOW, 16'h1503);
    reg_write(OFF_ALARM_DATE_HIGH, 16'h2412);
    for (int k = 2; k <= 9; k++) begin
      set_cur(ALARM_SET ^ flip(k));
      reg_write(OFF_CONTROL_ONE_HIGH, {4'h8, k[3:0], 8'h00});
      alarm_wait(48, 0, {4'h8, k[3:0], 8'h00});
      set_cur(ALARM_SET ^ flip(k + 1));
      alarm_wait(48, 1, {4'h0, k[3:0], 8'h00});
    end
    set_cur(ALARM_SET);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h8a00);
    alarm_wait(48, 0, 16'h8a00);
    reg_write(OFF_CONTROL_ONE_HIGH, 16'h0000);
  endtask : test_digits

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    clock        = 1'b0;
    rst_b        = 1'b0;
    por_b        = 1'b0;
    addr         = 4'h0;
    wr_data      = 16'h0000;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    osc_cnt      = 3'h0;
    osc_in       = 1'b0;
    tamper_input = 1'b1;
    {cur_time_low, cur_time_high, cur_date_low, cur_date_high} = '0;
    repeat (4) @(posedge clock);
    rst_b <= 1'b1;
    por_b <= 1'b1;
    test_reset_regs();
    test_storage();
    test_capture();
    test_prescale();
    test_alarm_counts();
    test_digits();
    finish_test();
  end
endmodule : rac_core_test

// [hw/rac_core.sv]
// rac_core: alarm with repeat, timestamp capture and calibration regs.
// assumes calendar counters on clock supply cur_* in the same domain;
// tamper_input and osc_in are asynchronous pins.
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rac_core
  import rac_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
)(
  // clock and resets
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        por_b,
  // register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [15:0] rd_data,
  // running calendar
  input  wire logic [15:0] cur_time_low,
  input  wire logic [15:0] cur_time_high,
  input  wire logic [15:0] cur_date_low,
  input  wire logic [15:0] cur_date_high,
  // pins
  input  wire logic        osc_in,
  input  wire logic        tamper_input,
  // events and status
  output logic             half_tick,
  output logic             alarm_irq,
  output logic             capture_irq,
  output logic             clock_pin_output_enable
);

  if (ADDR_WIDTH != ADDR_W) begin : g_addr_check
    $error("rac_core supports only a 4-bit address");
  end

  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  typedef struct packed {
    logic        capture_enable;
    logic        clk_oe;
    logic        alarm_on;
    logic        endless_repeat;
    logic [3:0]  interval;
    logic [7:0]  repeat_count;
    logic [15:0] coarse;
    logic [4:0]  fine_prescale;
    logic [15:0] alm_tl;
    logic [15:0] alm_th;
    logic [15:0] alm_dl;
    logic [15:0] alm_dh;
    logic        capture_event_flag;
    logic [1:0]  tmp_sync;
    logic        tmp_prev;
    logic        prev_match;
    logic        alarm_pulse;
    logic        cap_pulse;
    logic [15:0] rd_data;
  } rac_core_type;

  typedef struct packed {
    logic [15:0] th;
    logic [15:0] dl;
    logic [15:0] dh;
  } rac_stamp_type;

  rac_core_type  q;
  rac_core_type  d;
  rac_stamp_type ts_q;
  rac_stamp_type ts_d;

  logic sec_phase;
  logic wr_ctrl_high;
  logic s1, s10, m1, m10, hr, wd, dy, mo;
  logic match;
  logic fire;
  logic alarm_event;
  logic tamper_fall;
  logic manual_cap;
  logic capture;
  logic [15:0] keep_th, keep_dl, keep_dh;

  rac_prescale u_prescale (
    .clock      (clock),
    .rst_b      (rst_b),
    .osc_in     (osc_in),
    .coarse_div (q.coarse),
    .fine_div   (q.fine_prescale),
    .half_tick  (half_tick),
    .sec_phase  (sec_phase)
  );

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    ts_d = ts_q;
    wr_ctrl_high = wr_en && (addr == OFF_CONTROL_ONE_HIGH);
    // full-word storage while capture is off
    keep_th = q.capture_enable ? MASK_TIME_HIGH : 16'hffff;
    keep_dl = q.capture_enable ? MASK_DATE_LOW : 16'hffff;
    keep_dh = q.capture_enable ? MASK_DATE_HIGH : 16'hffff;

    // digit comparators
    s1  = cur_time_low[11:8]  == q.alm_tl[11:8];
    s10 = cur_time_low[14:12] == q.alm_tl[14:12];
    m1  = cur_time_high[3:0]  == q.alm_th[3:0];
    m10 = cur_time_high[6:4]  == q.alm_th[6:4];
    hr  = cur_time_high[13:8] == q.alm_th[13:8];
    wd  = cur_date_low[2:0]   == q.alm_dl[2:0];
    dy  = cur_date_low[13:8]  == q.alm_dl[13:8];
    mo  = cur_date_high[4:0]  == q.alm_dh[4:0];

    // interval select picks digits that must agree
    case (q.interval)
      IVL_TEN_SECONDS: match = s1;
      IVL_MINUTE:      match = s1 & s10;
      IVL_TEN_MINUTES: match = s1 & s10 & m1;
      IVL_HOUR:        match = s1 & s10 & m1 & m10;
      IVL_DAY:         match = s1 & s10 & m1 & m10 & hr;
      IVL_WEEK:        match = s1 & s10 & m1 & m10 & hr & wd;
      IVL_MONTH:       match = s1 & s10 & m1 & m10 & hr & dy;
      IVL_YEAR:        match = s1 & s10 & m1 & m10 & hr & dy & mo;
      default:         match = 1'b0;
    endcase

    case (q.interval)
      IVL_HALF_SECOND: fire = 1'b1;
      IVL_SECOND:      fire = sec_phase;
      default:         fire = match & ~q.prev_match;
    endcase
    alarm_event = q.alarm_on & half_tick & fire;

    // tamper pin sync and falling edge
    d.tmp_sync = {q.tmp_sync[0], tamper_input};
    d.tmp_prev = q.tmp_sync[1];
    tamper_fall = q.tmp_prev & ~q.tmp_sync[1];
    manual_cap = wr_en && (addr == OFF_STATUS) &&
                 wr_data[BIT_CAPTURE_EVENT];
    capture = q.capture_enable && !q.capture_event_flag &&
              (tamper_fall || manual_cap);

    // register writes, reserved bits masked; timestamp words masked only while capture is on
    if (wr_en) begin
      case (addr)
        OFF_CONTROL_ONE_LOW: begin
          d.capture_enable = wr_data[BIT_CAPTURE_ENABLE];
          d.clk_oe = wr_data[BIT_CLOCK_PIN_OE];
        end
        OFF_CONTROL_ONE_HIGH: begin
          d.alarm_on = wr_data[BIT_ALARM_ON];
          d.endless_repeat = wr_data[BIT_ENDLESS_REPEAT];
          d.interval = wr_data[INTERVAL_LSB +: 4];
          d.repeat_count = wr_data[REPEAT_LSB +: 8];
        end
        OFF_STATUS: begin
          if (!wr_data[BIT_CAPTURE_EVENT]) begin
            d.capture_event_flag = 1'b0;
          end
        end
        OFF_COARSE_PRESCALE: d.coarse = wr_data;
        OFF_FINE_PRESCALE:   d.fine_prescale = wr_data[4:0];
        OFF_TS_TIME_HIGH:    ts_d.th = wr_data & keep_th;
        OFF_TS_DATE_LOW:     ts_d.dl = wr_data & keep_dl;
        OFF_TS_DATE_HIGH:    ts_d.dh = wr_data & keep_dh;
        OFF_ALARM_TIME_LOW:  d.alm_tl = wr_data & MASK_TIME_LOW;
        OFF_ALARM_TIME_HIGH: d.alm_th = wr_data & MASK_TIME_HIGH;
        OFF_ALARM_DATE_LOW:  d.alm_dl = wr_data & MASK_DATE_LOW;
        OFF_ALARM_DATE_HIGH: d.alm_dh = wr_data & MASK_DATE_HIGH;
        default: ;
      endcase
    end

    // capture wins over stored value and sets the flag
    if (capture) begin
      ts_d.th = cur_time_high & MASK_TIME_HIGH;
      ts_d.dl = cur_date_low & MASK_DATE_LOW;
      ts_d.dh = cur_date_high & MASK_DATE_HIGH;
      d.capture_event_flag = 1'b1;
    end
    d.cap_pulse = capture;

    // first-match tracking; armed only while enabled
    if (!q.alarm_on) begin
      d.prev_match = 1'b1;
    end else if (half_tick) begin
      d.prev_match = match;
    end

    // repeat bookkeeping overrides a same-cycle write
    if (alarm_event) begin
      if (q.repeat_count != 8'h00) begin
        d.repeat_count = q.repeat_count - 8'h01;
      end else if (q.endless_repeat) begin
        d.repeat_count = REPEAT_MAX;
      end else begin
        d.alarm_on = 1'b0;
      end
    end
    d.alarm_pulse = alarm_event;

    // read data, one cycle after the strobe
    d.rd_data = 16'h0000;
    if (rd_en) begin
      case (addr)
        OFF_CONTROL_ONE_LOW: begin
          d.rd_data[BIT_CAPTURE_ENABLE] = q.capture_enable;
          d.rd_data[BIT_CLOCK_PIN_OE] = q.clk_oe;
        end
        OFF_CONTROL_ONE_HIGH: begin
          d.rd_data[BIT_ALARM_ON] = q.alarm_on;
          d.rd_data[BIT_ENDLESS_REPEAT] = q.endless_repeat;
          d.rd_data[INTERVAL_LSB +: 4] = q.interval;
          d.rd_data[REPEAT_LSB +: 8] = q.repeat_count;
        end
        OFF_STATUS:
          d.rd_data[BIT_CAPTURE_EVENT] = q.capture_event_flag;
        OFF_COARSE_PRESCALE: d.rd_data = q.coarse;
        OFF_FINE_PRESCALE:   d.rd_data[4:0] = q.fine_prescale;
        OFF_TS_TIME_HIGH:    d.rd_data = ts_q.th & keep_th;
        OFF_TS_DATE_LOW:     d.rd_data = ts_q.dl & keep_dl;
        OFF_TS_DATE_HIGH:    d.rd_data = ts_q.dh & keep_dh;
        OFF_ALARM_TIME_LOW:  d.rd_data = q.alm_tl;
        OFF_ALARM_TIME_HIGH: d.rd_data = q.alm_th;
        OFF_ALARM_DATE_LOW:  d.rd_data = q.alm_dl;
        OFF_ALARM_DATE_HIGH: d.rd_data = q.alm_dh;
        default:             d.rd_data = 16'h0000;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // state registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{coarse: COARSE_RST, fine_prescale: FINE_RST,
             prev_match: 1'b1, tmp_sync: 2'b11, tmp_prev: 1'b1,
             default: '0};
    end else begin
      q <= d;
    end
  end

  // timestamp storage cleared by power-on only
  always_ff @(posedge clock or negedge por_b) begin
    if (!por_b) begin
      ts_q <= '0;
    end else begin
      ts_q <= ts_d;
    end
  end

  assign rd_data = q.rd_data;
  assign alarm_irq = q.alarm_pulse;
  assign capture_irq = q.cap_pulse;
  assign clock_pin_output_enable = q.clk_oe;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_ts_time_zero: assert property (
    rd_en && q.capture_enable && addr == OFF_TS_TIME_HIGH
    |=> (rd_data & ~MASK_TIME_HIGH) == 16'h0000)
    else $error("timestamp time high reserved bit set");

  a_ts_date_zero: assert property (
    rd_en && q.capture_enable && addr == OFF_TS_DATE_LOW
    |=> (rd_data & ~MASK_DATE_LOW) == 16'h0000)
    else $error("timestamp date low reserved bit set");

  a_ts_year_zero: assert property (
    rd_en && q.capture_enable && addr == OFF_TS_DATE_HIGH
    |=> (rd_data & ~MASK_DATE_HIGH) == 16'h0000)
    else $error("timestamp date high reserved bit set");

  a_capture_loads: assert property (
    capture |=> ts_q.th == ($past(cur_time_high) & MASK_TIME_HIGH) &&
    ts_q.dl == ($past(cur_date_low) & MASK_DATE_LOW) &&
    ts_q.dh == ($past(cur_date_high) & MASK_DATE_HIGH) &&
    q.capture_event_flag && capture_irq)
    else $error("capture did not load time and flag");

  a_capture_blocked: assert property (
    q.capture_event_flag && !wr_en |=> $stable(ts_q))
    else $error("timestamp changed while flag set");

  a_repeat_dec: assert property (
    alarm_event && q.repeat_count != 8'h00 && !wr_ctrl_high
    |=> q.repeat_count == $past(q.repeat_count) - 8'h01 && q.alarm_on)
    else $error("repeat count not decremented");

  a_last_alarm_off: assert property (
    alarm_event && q.repeat_count == 8'h00 && !q.endless_repeat
    |=> !q.alarm_on)
    else $error("alarm stayed on after last repeat");

  a_endless_wrap: assert property (
    alarm_event && q.repeat_count == 8'h00 && q.endless_repeat
    |=> q.repeat_count == REPEAT_MAX && q.alarm_on)
    else $error("endless repeat did not wrap");

  a_irq_on_alarm: assert property (
    alarm_irq == $past(q.alarm_on && half_tick && fire))
    else $error("alarm interrupt mismatch");

  a_no_alarm_off: assert property (
    !q.alarm_on |=> !alarm_irq)
    else $error("alarm fired while disabled");

  a_first_match: assert property (
    alarm_irq && $past(q.interval) > IVL_SECOND
    |-> $past(match) && !$past(q.prev_match))
    else $error("alarm fired without a fresh match");

  c_alarm_last: cover property (@(posedge clock) disable iff (!rst_b)
    alarm_event && q.repeat_count == 8'h00 && !q.endless_repeat);
  c_endless: cover property (@(posedge clock) disable iff (!rst_b)
    alarm_event && q.endless_repeat && q.repeat_count == 8'h00);
  c_tamper: cover property (@(posedge clock) disable iff (!rst_b)
    capture && tamper_fall);
  c_manual: cover property (@(posedge clock) disable iff (!rst_b)
    capture && manual_cap);

endmodule : rac_core

// [hw/rac_pkg.sv]
// rac_pkg: register map, field layout, reset values and interval codes
// for the alarm, calibration and timestamp part of the calendar clock.
// assumes a 16-bit register port with a 4-bit word address.
package rac_pkg;

  // ------------------------------------------------------------------
  // register port geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [3:0] OFF_CONTROL_ONE_LOW  = 4'h0;
  localparam logic [3:0] OFF_CONTROL_ONE_HIGH = 4'h1;
  localparam logic [3:0] OFF_STATUS           = 4'h2;
  localparam logic [3:0] OFF_COARSE_PRESCALE  = 4'h3;
  localparam logic [3:0] OFF_FINE_PRESCALE    = 4'h4;
  localparam logic [3:0] OFF_TS_TIME_HIGH     = 4'h5;
  localparam logic [3:0] OFF_TS_DATE_LOW      = 4'h6;
  localparam logic [3:0] OFF_TS_DATE_HIGH     = 4'h7;
  localparam logic [3:0] OFF_ALARM_TIME_LOW   = 4'h8;
  localparam logic [3:0] OFF_ALARM_TIME_HIGH  = 4'h9;
  localparam logic [3:0] OFF_ALARM_DATE_LOW   = 4'ha;
  localparam logic [3:0] OFF_ALARM_DATE_HIGH  = 4'hb;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_CAPTURE_ENABLE   = 0;
  localparam int BIT_CLOCK_PIN_OE     = 7;
  localparam int BIT_ALARM_ON         = 15;
  localparam int BIT_ENDLESS_REPEAT   = 14;
  localparam int BIT_CAPTURE_EVENT    = 3;
  localparam int INTERVAL_LSB         = 8;
  localparam int REPEAT_LSB           = 0;

  // implemented bits of each calendar-format register
  localparam logic [15:0] MASK_TIME_LOW  = 16'h7f00;
  localparam logic [15:0] MASK_TIME_HIGH = 16'h3f7f;
  localparam logic [15:0] MASK_DATE_LOW  = 16'h3f07;
  localparam logic [15:0] MASK_DATE_HIGH = 16'hff1f;

  // ------------------------------------------------------------------
  // reset values and endless-repeat reload
  // ------------------------------------------------------------------
  localparam logic [15:0] COARSE_RST = 16'h4000;
  localparam logic [4:0]  FINE_RST   = 5'h00;
  localparam logic [7:0]  REPEAT_MAX = 8'hff;
  // one oscillator edge in the 16.5 fixed-point accumulator
  localparam logic [20:0] PRESCALE_STEP = 21'h000020;

  // ------------------------------------------------------------------
  // alarm interval select codes
  // ------------------------------------------------------------------
  localparam logic [3:0] IVL_HALF_SECOND = 4'h0;
  localparam logic [3:0] IVL_SECOND      = 4'h1;
  localparam logic [3:0] IVL_TEN_SECONDS = 4'h2;
  localparam logic [3:0] IVL_MINUTE      = 4'h3;
  localparam logic [3:0] IVL_TEN_MINUTES = 4'h4;
  localparam logic [3:0] IVL_HOUR        = 4'h5;
  localparam logic [3:0] IVL_DAY         = 4'h6;
  localparam logic [3:0] IVL_WEEK        = 4'h7;
  localparam logic [3:0] IVL_MONTH       = 4'h8;
  localparam logic [3:0] IVL_YEAR        = 4'h9;

endpackage : rac_pkg

// [hw/rac_prescale.sv]
// rac_prescale: 21-bit calibrated divider giving half-second ticks.
// assumes osc_in is the crystal clock seen as a pin, slow against clock.
`timescale 1ns/1ps
module rac_prescale
  import rac_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // oscillator pin and calibration
  input  wire logic        osc_in,
  input  wire logic [15:0] coarse_div,
  input  wire logic [4:0]  fine_div,
  // ticks
  output logic             half_tick,
  output logic             sec_phase
);

  typedef struct packed {
    logic [1:0]  sync;
    logic        prev;
    logic [20:0] acc;
    logic        tick;
    logic        phase;
  } rac_pre_type;

  rac_pre_type q;
  rac_pre_type d;
  logic [20:0] limit;
  logic [21:0] sum;
  logic        rise;

  // ------------------------------------------------------------------
  // divider
  // ------------------------------------------------------------------
  always_comb begin
    d = q;
    d.sync = {q.sync[0], osc_in};
    d.prev = q.sync[1];
    rise = q.sync[1] & ~q.prev;
    // coarse and fine joined; larger value, slower tick
    limit = {coarse_div, fine_div};
    if (limit < PRESCALE_STEP) begin
      limit = PRESCALE_STEP;
    end
    // spare top bit so a limit near full scale cannot wrap the sum
    sum = {1'b0, q.acc} + {1'b0, PRESCALE_STEP};
    d.tick = 1'b0;
    if (rise) begin
      if (sum >= {1'b0, limit}) begin
        d.acc = 21'(sum - {1'b0, limit});
        d.tick = 1'b1;
        d.phase = ~q.phase;
      end else begin
        d.acc = sum[20:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign half_tick = q.tick;
  assign sec_phase = q.phase;

  a_tick_needs_edge: assert property (
    @(posedge clock) disable iff (!rst_b)
    half_tick |-> $past(q.sync[1]) && !$past(q.prev))
    else $error("half tick without oscillator edge");

endmodule : rac_prescale
